// [hw/scp_chain_port.sv]
// Purpose: daisy-chain serial port, watchdog and open-drain gp pins
// Assumes: link clock far slower than i_mclk; mode 0 spi
// Notes:
// Notes on behaviour
// - downstream select follows upstream select.
// - downstream clock follows upstream clock.
// - bidirectional chain data sends down and receives back.
// - top of stack: ignore chain data, disable clock and select out.
// - not top: pass data down and accept returned data.
// - watchdog asserts after one to 2.5 s with no valid command.
// - watchdog expiry returns configuration to defaults.
// - watchdog output is open-drain, low when asserted.
// - gp bit zero pulls its pin low.
// - gp bit one releases the pin.
// - gp read returns actual pin level.
// - mode strap high: upstream pins are voltage logic.
// - mode strap low: current signalling, data-out unused.
// - voltage mode data-out is open-drain pulldown; host pulls up.
// - watchdog expiry switches off discharge outputs.
// - exchange is spi compatible: select, clock, data in, out.
`timescale 1ns/1ps
module scp_chain_port
	import scp_pkg::*;
#(
	parameter int unsigned WDOG_LIMIT = scp_pkg::WDOG_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_chain_select_in_n,
	input wire logic i_chain_clock_in,
	input wire logic i_upstream_data_in,
	input wire logic i_top_of_stack_strap,
	input wire logic i_signalling_mode_strap,
	input wire logic i_chain_data_bidir,
	input wire logic i_gp_pin_one,
	input wire logic i_gp_pin_two,
	input wire logic i_reply_bit,
	input wire logic i_cfg_wr,
	input wire logic [scp_pkg::CFG_W-1:0] i_cfg_wdata,
	input wire logic [scp_pkg::GP_W-1:0] i_gp_wdata,
	input wire logic i_dis_wr,
	input wire logic [11:0] i_dis_wdata,
	output logic o_chain_select_out_n,
	output logic o_chain_clock_out,
	output logic o_chain_data_bidir,
	output logic o_chain_data_bidir_oe,
	output logic o_upstream_data_out,
	output logic o_upstream_data_out_oe,
	output logic o_upstream_data_in,
	output logic o_upstream_data_in_oe,
	output logic o_watchdog_out_n,
	output logic o_watchdog_out_n_oe,
	output logic o_gp_pin_one,
	output logic o_gp_pin_one_oe,
	output logic o_gp_pin_two,
	output logic o_gp_pin_two_oe,
	output logic [scp_pkg::GP_W-1:0] o_gp_level,
	output logic [scp_pkg::CFG_W-1:0] o_cfg,
	output logic [11:0] o_discharge,
	output logic o_cmd_valid,
	output logic [scp_pkg::CMD_BITS-1:0] o_cmd
);
	import scp_pkg::*;

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic [7:0] raw;
	logic [7:0] syn;
	// select goes through inverted so cleared stages read as deselected;
	// otherwise a false frame would follow every reset
	assign raw = {~i_chain_select_in_n, i_chain_clock_in,
		i_upstream_data_in, i_top_of_stack_strap, i_signalling_mode_strap,
		i_chain_data_bidir, i_gp_pin_two, i_gp_pin_one};

	scp_sync #(.W(8)) u_sync (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_async(raw),
		.o_sync(syn)
	);

	logic cs_n, sck, upstream_data_in, top_of_stack_strap, signalling_mode_strap, dn_in;
	assign cs_n = ~syn[7];
	assign sck = syn[6];
	assign upstream_data_in = syn[5];
	assign top_of_stack_strap = syn[4];
	assign signalling_mode_strap = syn[3];
	assign dn_in = syn[2];
	// level bit n belongs to gp bit n
	assign o_gp_level = syn[1:0];

	// ==========================================================
	// link edge detection
	// ==========================================================
	logic sck_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck;
		end
	end
	logic rise, fall;
	assign rise = sck & ~sck_q & ~cs_n;
	assign fall = ~sck & sck_q & ~cs_n;

	// ==========================================================
	// downstream forwarding
	// ==========================================================
	// registered copies of the pins; top of stack parks select and clock idle
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_chain_select_out_n <= 1'b1;
			o_chain_clock_out <= 1'b0;
			o_chain_data_bidir <= 1'b0;
		end else begin
			o_chain_select_out_n <= top_of_stack_strap ? 1'b1 : cs_n;
			o_chain_clock_out <= top_of_stack_strap ? 1'b0 : sck;
			o_chain_data_bidir <= upstream_data_in;
		end
	end
	// downstream data is driven while the command goes down, then released
	// so that the device below can return its reply in the same frame
	logic rx_q;
	assign o_chain_data_bidir_oe = ~top_of_stack_strap & ~cs_n & ~o_chain_select_out_n
		& ~rx_q;

	property p_select_follow;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_chain_select_out_n == ($past(top_of_stack_strap) | $past(cs_n));
	endproperty
	a_select_follow: assert property (p_select_follow)
		else $error("select out does not follow select in");

	property p_clock_follow;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_chain_clock_out == ($past(sck) & ~$past(top_of_stack_strap));
	endproperty
	a_clock_follow: assert property (p_clock_follow)
		else $error("clock out does not follow clock in");

	property p_top_no_drive;
		@(posedge i_mclk) disable iff (i_sys_rst)
		top_of_stack_strap |-> !o_chain_data_bidir_oe;
	endproperty
	a_top_no_drive: assert property (p_top_no_drive)
		else $error("chain data driven at top of stack");

	// ==========================================================
	// command shift register and watchdog
	// ==========================================================
	logic [CMD_BITS-1:0] sh_q;
	logic [CNT_W-1:0] cnt_q;
	// only the first command of a frame is taken; the rest of the frame
	// carries the reply back up
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sh_q <= '0;
			cnt_q <= '0;
			rx_q <= 1'b0;
			o_cmd_valid <= 1'b0;
			o_cmd <= '0;
		end else begin
			o_cmd_valid <= 1'b0;
			if (cs_n) begin
				cnt_q <= '0;
				rx_q <= 1'b0;
			end else if (rise && !rx_q) begin
				sh_q <= {sh_q[CMD_BITS-2:0], upstream_data_in};
				if (cnt_q == CNT_W'(CMD_BITS - 1)) begin
					cnt_q <= '0;
					rx_q <= 1'b1;
					o_cmd_valid <= 1'b1;
					o_cmd <= {sh_q[CMD_BITS-2:0], upstream_data_in};
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end

	logic [WDOG_W-1:0] wd_q;
	logic wd_exp_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wd_q <= '0;
			wd_exp_q <= 1'b0;
		end else if (o_cmd_valid) begin
			wd_q <= '0;
			wd_exp_q <= 1'b0;
		end else if (wd_q == WDOG_W'(WDOG_LIMIT - 1)) begin
			wd_exp_q <= 1'b1;
		end else begin
			wd_q <= wd_q + 1'b1;
		end
	end
	assign o_watchdog_out_n = 1'b0;
	assign o_watchdog_out_n_oe = wd_exp_q;

	property p_cmd_pulse;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_cmd_valid |=> !o_cmd_valid;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse)
		else $error("command valid longer than one cycle");

	property p_rx_release;
		@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(rx_q) |-> o_cmd_valid && !o_chain_data_bidir_oe;
	endproperty
	a_rx_release: assert property (p_rx_release)
		else $error("chain data not released after the command");

	property p_wdog_release;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_cmd_valid |=> !o_watchdog_out_n_oe;
	endproperty
	a_wdog_release: assert property (p_wdog_release)
		else $error("watchdog not released by a command");

	property p_wdog_hold;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_watchdog_out_n_oe && !o_cmd_valid |=> o_watchdog_out_n_oe;
	endproperty
	a_wdog_hold: assert property (p_wdog_hold)
		else $error("watchdog dropped without a command");

	// ==========================================================
	// configuration, gp pins, discharge
	// ==========================================================
	logic [GP_W-1:0] gp_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_cfg <= CFG_RESET;
			gp_q <= GP_RESET;
			o_discharge <= '0;
		end else if (wd_exp_q) begin
			o_cfg <= CFG_RESET;
			gp_q <= GP_RESET;
			o_discharge <= '0;
		end else begin
			if (i_cfg_wr) begin
				o_cfg <= i_cfg_wdata;
				gp_q <= i_gp_wdata;
			end
			if (i_dis_wr) begin
				o_discharge <= i_dis_wdata;
			end
		end
	end
	assign o_gp_pin_one = 1'b0;
	assign o_gp_pin_two = 1'b0;
	assign o_gp_pin_one_oe = ~gp_q[0];
	assign o_gp_pin_two_oe = ~gp_q[1];

	property p_wdog_defaults;
		@(posedge i_mclk) disable iff (i_sys_rst)
		o_watchdog_out_n_oe |=> o_cfg == CFG_RESET && gp_q == GP_RESET
			&& o_discharge == '0;
	endproperty
	a_wdog_defaults: assert property (p_wdog_defaults)
		else $error("configuration not at defaults under watchdog");

	// ==========================================================
	// upstream reply path
	// ==========================================================
	logic rep_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rep_q <= 1'b1;
		end else if (fall) begin
			rep_q <= top_of_stack_strap ? i_reply_bit : dn_in;
		end
	end
	// voltage mode: open-drain low on data-out; current mode on data-in
	assign o_upstream_data_out = 1'b0;
	assign o_upstream_data_out_oe = signalling_mode_strap & ~cs_n & ~rep_q;
	assign o_upstream_data_in = 1'b0;
	assign o_upstream_data_in_oe = ~signalling_mode_strap & ~cs_n & ~rep_q;

	property p_reply_quiet;
		@(posedge i_mclk) disable iff (i_sys_rst)
		cs_n |-> !o_upstream_data_out_oe && !o_upstream_data_in_oe;
	endproperty
	a_reply_quiet: assert property (p_reply_quiet)
		else $error("reply driven while deselected");

	property p_reply_mode;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!(signalling_mode_strap ? o_upstream_data_in_oe : o_upstream_data_out_oe);
	endproperty
	a_reply_mode: assert property (p_reply_mode)
		else $error("reply on the pin of the other mode");
endmodule // scp_chain_port

// [hw/scp_pkg.sv]
// Purpose: shared constants for the stack monitor chain port
// Assumes: system clock of 25 MHz
// Notes: watchdog figures are in milliseconds
package scp_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned WDOG_MIN_MS = 1000;
	localparam int unsigned WDOG_MAX_MS = 2500;
	// timeout sits at the least figure, rounded down to whole cycles
	localparam int unsigned WDOG_CYCLES = (CLK_HZ / 1000) * WDOG_MIN_MS;
	localparam int unsigned WDOG_W = 26;
	localparam int unsigned CMD_BITS = 16;
	localparam int unsigned CNT_W = 5;
	localparam int unsigned CFG_W = 8;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int unsigned GP_W = 2;
	localparam logic [1:0] GP_RESET = 2'h3;
endpackage

// [hw/scp_sync.sv]
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: one clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module scp_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // scp_sync

// [verif/scp_chain_partner.sv]
// Purpose: model of the next chained device below the port
// Assumes: mode 0 link, select active low
// Notes: a released line shows the inverse of its last bit
`timescale 1ns/1ps
module scp_chain_partner #(
	parameter logic [15:0] REPLY = 16'hc35a
) (
	input wire logic i_select_n,
	input wire logic i_clock,
	output logic o_data,
	output logic o_data_oe
);
	logic [15:0] sh_q = REPLY;
	logic [4:0] n_q = 5'h00;
	logic last_q = 1'b0;
	// count the command bits; the line is ours only once all 16 are in
	always @(posedge i_clock or posedge i_select_n) begin
		if (i_select_n) begin
			n_q <= 5'h00;
		end else if (n_q != 5'h10) begin
			n_q <= n_q + 5'h01;
		end
	end
	// reply shifts out msb first on falling clock
	always @(negedge i_clock or posedge i_select_n) begin
		if (i_select_n) begin
			last_q <= sh_q[15];
			sh_q <= REPLY;
		end else if (o_data_oe) begin
			sh_q <= {sh_q[14:0], sh_q[15]};
		end
	end
	assign o_data_oe = ~i_select_n & (n_q == 5'h10);
	assign o_data = o_data_oe ? sh_q[15] : ~last_q;
endmodule // scp_chain_partner

// [verif/scp_chain_port_tb.sv]
// Purpose: self-checking bench of the chain port
// Assumes: both upstream modes, pulled-up gp pins and reply line
// Notes: watchdog limit shortened to keep the run short
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
$display("Error %0t mismatch", $time); end end
module scp_chain_port_tb;
	import scp_pkg::*;
	localparam int LIM = 400;
	localparam logic [15:0] RPL = 16'hc35a;
	localparam logic [15:0] PAT = 16'h96e1;
	logic i_mclk = 0, i_sys_rst = 1, sel_n = 1, clk_in = 0, din = 0, top = 0;
	logic rep = 1, cfg_wr = 0, dis_wr = 0, ext1 = 1, ext2 = 1, vm = 0;
	logic [7:0] cfg_wd = 0;
	logic [1:0] gp_wd = 2'h3;
	logic [11:0] dis_wd = 0;
	logic cs_o, ck_o, bd, bd_oe, do_oe, in_oe, wd_n, wd_oe, g1, g1_oe;
	logic g2, g2_oe, p_d, p_oe, cv;
	logic [1:0] lvl;
	logic [7:0] cfg;
	logic [11:0] dis;
	logic [15:0] cmd;
	int fail_count = 0, tests_run = 0, cyc = 0, last_cyc = 0, n_cv = 0;
	wire bidir = bd_oe ? bd : p_d;
	initial forever #20 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cv) begin
			n_cv <= n_cv + 1;
			last_cyc <= cyc;
		end
	end
	scp_chain_port #(.WDOG_LIMIT(LIM)) dut (.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst), .i_chain_select_in_n(sel_n),
		.i_chain_clock_in(clk_in), .i_upstream_data_in(din),
		.i_top_of_stack_strap(top), .i_signalling_mode_strap(vm),
		.i_chain_data_bidir(bidir), .i_gp_pin_one(g1_oe ? g1 : ext1),
		.i_gp_pin_two(g2_oe ? g2 : ext2), .i_reply_bit(rep),
		.i_cfg_wr(cfg_wr), .i_cfg_wdata(cfg_wd), .i_gp_wdata(gp_wd),
		.i_dis_wr(dis_wr), .i_dis_wdata(dis_wd), .o_chain_select_out_n(cs_o),
		.o_chain_clock_out(ck_o), .o_chain_data_bidir(bd),
		.o_chain_data_bidir_oe(bd_oe), .o_upstream_data_out(),
		.o_upstream_data_out_oe(do_oe), .o_upstream_data_in(),
		.o_upstream_data_in_oe(in_oe), .o_watchdog_out_n(wd_n),
		.o_watchdog_out_n_oe(wd_oe), .o_gp_pin_one(g1),
		.o_gp_pin_one_oe(g1_oe), .o_gp_pin_two(g2), .o_gp_pin_two_oe(g2_oe),
		.o_gp_level(lvl), .o_cfg(cfg), .o_discharge(dis), .o_cmd_valid(cv),
		.o_cmd(cmd));
	scp_chain_partner #(.REPLY(RPL)) partner (.i_select_n(cs_o),
		.i_clock(ck_o),
		.o_data(p_d), .o_data_oe(p_oe));
	// ==========================================
	// scenarios
	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// half a link clock period of 160 ns
	task automatic hold();
		repeat (4) @(negedge i_mclk);
		`CHK(ck_o, top ? 1'b0 : clk_in)
		`CHK(cs_o, top ? 1'b1 : sel_n)
		`CHK(vm ? in_oe : do_oe, 1'b0)
		`CHK(bd_oe & p_oe, 1'b0)
		if (top) `CHK(bd_oe, 1'b0)
		else `CHK(bd, din)
	endtask
	// one frame: 16 command bits down, then 16 reply bits back up
	task automatic send(input logic [15:0] w, input logic t, input logic v);
		int c0;
		logic [15:0] rx;
		top = t;
		vm = v;
		c0 = n_cv;
		rx = 16'h0000;
		sel_n = 0;
		for (int i = 31; i >= 0; i--) begin
			din = (i > 15) ? w[i - 16] : 1'b0;
			rep = (i < 16) ? PAT[i] : 1'b1;
			hold();
			// the host's pull-up makes a released reply read high
			if (i < 16) rx[i] = ~(v ? do_oe : in_oe);
			clk_in = 1;
			hold();
			clk_in = 0;
		end
		sel_n = 1;
		hold();
		`CHK(n_cv - c0, 1)
		`CHK(cmd, w)
		`CHK(rx, t ? PAT : RPL)
		`CHK(wd_oe, 1'b0)
	endtask
	task automatic gp();
		gp_wd = 2'h2;
		cfg_wd = 8'h5a;
		dis_wd = 12'h9c3;
		cfg_wr = 1;
		dis_wr = 1;
		@(negedge i_mclk);
		cfg_wr = 0;
		dis_wr = 0;
		repeat (4) @(negedge i_mclk);
		`CHK(g1_oe, 1'b1)
		`CHK(g2_oe, 1'b0)
		`CHK({lvl, cfg, dis}, {2'h2, 8'h5a, 12'h9c3})
		ext2 = 0;
		repeat (4) @(negedge i_mclk);
		`CHK(lvl, 2'h0)
	endtask
	task automatic wdog();
		int n;
		for (n = 0; n < 600 && wd_oe !== 1'b1; n++) @(negedge i_mclk);
		if (n == 600) begin
			fail_count++;
			report_and_stop();
		end
		`CHK(cyc - last_cyc inside {[LIM - 2 : LIM + 2]}, 1'b1)
		@(negedge i_mclk);
		`CHK(wd_n, 1'b0)
		`CHK({cfg, dis, g1_oe}, {CFG_RESET, 12'h000, 1'b0})
		send(16'ha5c3, 0, 0);
	endtask
	initial begin
		repeat (8) @(negedge i_mclk);
		i_sys_rst = 0;
		repeat (3) @(negedge i_mclk);
		send(16'h3ac5, 0, 0);
		send(16'h6d29, 0, 1);
		gp();
		wdog();
		send(16'h5c3a, 1, 0);
		report_and_stop();
	end
endmodule // scp_chain_port_tb
